// file: core/pec_pkg.sv
/*
  Shared constants and carrier types for the leadscrew pitch error compensator.
  Assumes one motion clock domain; users import the package or name its members with the pec_pkg:: prefix.
*/
package pec_pkg;

  localparam int TBL_DEPTH = 1024;
  localparam int ADDR_W    = 10;
  localparam int CORR_W    = 13;
  localparam int IVAL_W    = 20;
  localparam int POS_W     = 32;
  localparam int PEND_W    = 16;
  localparam int TOTAL_W   = 32;
  localparam int BUF_CNT_W = 2;

  // One count is 0.001 mm of diameter-referenced travel.
  localparam logic signed [CORR_W-1:0] CORR_MIN = -13'sh09f6;
  localparam logic signed [CORR_W-1:0] CORR_MAX = 13'sh09f6;

  // Interval limits in 0.001 mm: 1000 and 999999.
  localparam logic [IVAL_W-1:0] IVAL_MIN = 20'h003e8;
  localparam logic [IVAL_W-1:0] IVAL_MAX = 20'hf423f;
  localparam logic [IVAL_W-1:0] IVAL_ONE = 20'h00001;

  localparam logic [1:0]        PRIV_EDIT       = 2'h2;
  localparam logic [ADDR_W-1:0] ORIGIN_POS_ONLY = 10'h000;
  localparam logic [ADDR_W-1:0] ORIGIN_NEG_ONLY = 10'h0ff;

  localparam logic [BUF_CNT_W-1:0] BUF_EMPTY = 2'h0;
  localparam logic [BUF_CNT_W-1:0] BUF_ONE   = 2'h1;
  localparam logic [BUF_CNT_W-1:0] BUF_FULL  = 2'h2;

  // One command pulse towards the drive; dir high means positive travel.
  typedef struct packed {
    logic dir;
    logic isCorr;
  } pulse_s;

  // Per-axis compensation settings.
  typedef struct packed {
    logic              enable;
    logic [ADDR_W-1:0] origin;
    logic [ADDR_W-1:0] minPos;
    logic [ADDR_W-1:0] maxPos;
    logic [IVAL_W-1:0] interval;
  } comp_cfg_s;

  // Table edit request.
  typedef struct packed {
    logic                     we;
    logic [ADDR_W-1:0]        addr;
    logic signed [CORR_W-1:0] data;
  } tbl_wr_s;

endpackage : pec_pkg

// file: core/pec_table_mem.sv
/*
  Compensation table storage: one write port, one read port, registered read data.
  Assumes the owner clears it after reset; a read and a write of one address
  in the same cycle return the old value.
*/
`timescale 1ns/1ps
module pec_table_mem #(
  parameter int DEPTH  = pec_pkg::TBL_DEPTH,
  parameter int ADDR_W = pec_pkg::ADDR_W,
  parameter int DATA_W = pec_pkg::CORR_W
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  input  wire logic                     wrEn,
  input  wire logic [ADDR_W-1:0]        wrAddr,
  input  wire logic signed [DATA_W-1:0] wrData,
  input  wire logic                     rdEn,
  input  wire logic [ADDR_W-1:0]        rdAddr,
  output logic signed [DATA_W-1:0]      rdData
);

  logic signed [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule : pec_table_mem

// file: core/leadscrew_pitch_error_compensator.sv
/*
  Single-axis leadscrew pitch error compensator: tracks the commanded position,
  looks up a correction at each interval boundary and merges it as extra pulses
  into the command stream towards the servo drive, through a two-entry buffer.
  Assumes all inputs come from logic on ref_clk and that nominal steps leave
  idle cycles in which correction pulses can be sent.
*/
`timescale 1ns/1ps

// Summary of operation
// - Table entries hold signed corrections from -2550 to +2550, 0.001 mm each.
// - Table edits are refused unless privilege is level 2 and write switch is on.
// - A zero interval disables all pitch correction.
// - After any setting change corrections stay off until machine zero return.
// - Origin 0: positive interval k uses entry k; negative travel gets none.
// - Origin 0: entry N covers travel from (N-1) to N intervals.
// - Drive pulses equal nominal pulses plus the sum of crossed corrections.
// - Origin other than 0 or 255: positive interval k uses entry origin plus k.
// - Nonzero origin: negative interval k uses entry origin plus one minus k.
// - An origin other than 0 or 255 corrects both sides of machine zero.
// - Origin 255: negative interval k uses entry 256 minus k; positive none.
// - Origin 255: entry N covers (N-256) to (N-255) intervals.
// - The enable bit turns compensation on when one, off when zero.
// - Origin, minimum and maximum position numbers range 0 to 1023.
// - The interval is accepted from 1000 to 999999 units of 0.001 mm.
module leadscrew_pitch_error_compensator #(
  parameter int DEPTH = pec_pkg::TBL_DEPTH
) (
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  pec_pkg::comp_cfg_s      cfg,
  input  wire logic [1:0]         privLevel,
  input  wire logic               paramWriteOn,
  input  pec_pkg::tbl_wr_s        tblWr,
  output logic                    tblWrAck,
  output logic                    tblWrRefused,
  input  wire logic               homeDone,
  input  wire logic               stepValid,
  input  wire logic               stepDir,
  output logic                    stepReady,
  output logic                    driveValid,
  output pec_pkg::pulse_s         drivePulse,
  input  wire logic               driveReady,
  output logic                    compActive,
  output logic                    tableClearing,
  output logic signed [pec_pkg::TOTAL_W-1:0] compTotal
);
  import pec_pkg::*;

  typedef enum logic [2:0] {
    MODE_CLEAR   = 3'h1,
    MODE_UNHOMED = 3'h2,
    MODE_RUN     = 3'h4
  } mode_e;

  mode_e                     mode_reg;
  logic [ADDR_W-1:0]         clrAddr_reg;
  comp_cfg_s                 cfgPrev_reg;
  logic signed [POS_W-1:0]   idx_reg;
  logic [IVAL_W-1:0]         off_reg;
  logic                      rdPend_reg;
  logic                      rdSub_reg;
  logic signed [PEND_W-1:0]  pending_reg;
  logic signed [PEND_W-1:0]  pending_next;
  logic signed [TOTAL_W-1:0] total_reg;
  logic [BUF_CNT_W-1:0]      cnt_reg;
  logic [BUF_CNT_W-1:0]      cnt_next;
  pulse_s                    head_reg;
  pulse_s                    tail_reg;
  pulse_s                    pushData;
  logic                      valid_reg;
  logic                      stepReady_reg;
  logic                      ackReg;
  logic                      refReg;
  logic                      activeReg;
  logic                      clearing_reg;

  logic                      wrOk;
  logic                      cfgChanged;
  logic                      intervalOk;
  logic                      active;
  logic                      stepTake;
  logic                      crossPos;
  logic                      crossNeg;
  logic signed [POS_W-1:0]   bound;
  logic [ADDR_W:0]           sel;
  logic                      rdEn;
  logic signed [CORR_W-1:0]  rdData;
  logic signed [PEND_W-1:0]  addVal;
  logic                      emitCorr;
  logic                      push;
  logic                      pop;
  logic                      memWe;
  logic [ADDR_W-1:0]         memWrAddr;
  logic signed [CORR_W-1:0]  memWrData;

  // Entry for the interval whose upper boundary is b intervals from zero.
  // Valid bit on top, table address below.
  function automatic logic [ADDR_W:0] entry_select(
    input logic signed [POS_W-1:0] b,
    input comp_cfg_s               c
  );
    logic signed [POS_W:0] e;
    logic                  ok;
    e  = $signed({1'b0, c.origin}) + b;
    ok = (e >= $signed({1'b0, c.minPos})) && (e <= $signed({1'b0, c.maxPos}));
    if (c.origin == ORIGIN_POS_ONLY && b <= 0) begin
      ok = 1'b0;
    end
    if (c.origin == ORIGIN_NEG_ONLY && b > 0) begin
      ok = 1'b0;
    end
    return {ok, e[ADDR_W-1:0]};
  endfunction : entry_select

  // Table edits and the power-up clearing sweep share the write port.
  always_comb begin
    wrOk = tblWr.we && (mode_reg != MODE_CLEAR)
           && (privLevel == PRIV_EDIT) && paramWriteOn
           && (tblWr.data >= CORR_MIN) && (tblWr.data <= CORR_MAX);
    memWe     = wrOk || (mode_reg == MODE_CLEAR);
    memWrAddr = (mode_reg == MODE_CLEAR) ? clrAddr_reg : tblWr.addr;
    memWrData = (mode_reg == MODE_CLEAR) ? '0 : tblWr.data;
  end

  always_comb begin
    cfgChanged = (cfg != cfgPrev_reg) || wrOk;
    intervalOk = (cfg.interval >= IVAL_MIN) && (cfg.interval <= IVAL_MAX);
    active     = (mode_reg == MODE_RUN) && cfg.enable && intervalOk;
    stepTake   = stepValid && stepReady_reg;
    crossPos   = stepTake && stepDir && (off_reg == cfg.interval - IVAL_ONE);
    crossNeg   = stepTake && !stepDir && (off_reg == '0);
    bound      = crossPos ? idx_reg + POS_W'(1) : idx_reg;
    sel        = entry_select(bound, cfg);
    rdEn       = active && (crossPos || crossNeg) && sel[ADDR_W];
  end

  pec_table_mem #(
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W),
    .DATA_W (CORR_W)
  ) u_table (
    .clk    (ref_clk),
    .reset  (reset),
    .wrEn   (memWe),
    .wrAddr (memWrAddr),
    .wrData (memWrData),
    .rdEn   (rdEn),
    .rdAddr (sel[ADDR_W-1:0]),
    .rdData (rdData)
  );

  // Mode: clear the table, then wait for a machine zero return.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_reg    <= MODE_CLEAR;
      clrAddr_reg <= '0;
      cfgPrev_reg <= '0;
      clearing_reg <= 1'b1;
    end else begin
      cfgPrev_reg <= cfg;
      clearing_reg <= (mode_reg == MODE_CLEAR) && (clrAddr_reg != ADDR_W'(DEPTH - 1));
      unique case (mode_reg)
        MODE_CLEAR: begin
          clrAddr_reg <= clrAddr_reg + ADDR_W'(1);
          if (clrAddr_reg == ADDR_W'(DEPTH - 1)) begin
            mode_reg <= MODE_UNHOMED;
          end
        end
        MODE_UNHOMED: begin
          if (homeDone && !cfgChanged) begin
            mode_reg <= MODE_RUN;
          end
        end
        MODE_RUN: begin
          if (cfgChanged) begin
            mode_reg <= MODE_UNHOMED;
          end
        end
        default: begin
          mode_reg <= MODE_CLEAR;
        end
      endcase
    end
  end

  // Commanded position as whole intervals plus the offset inside one.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      idx_reg <= '0;
      off_reg <= '0;
    end else if (homeDone) begin
      idx_reg <= '0;
      off_reg <= '0;
    end else if (stepTake && intervalOk) begin
      if (crossPos) begin
        idx_reg <= idx_reg + POS_W'(1);
        off_reg <= '0;
      end else if (crossNeg) begin
        idx_reg <= idx_reg - POS_W'(1);
        off_reg <= cfg.interval - IVAL_ONE;
      end else if (stepDir) begin
        off_reg <= off_reg + IVAL_ONE;
      end else begin
        off_reg <= off_reg - IVAL_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdPend_reg <= 1'b0;
      rdSub_reg  <= 1'b0;
    end else begin
      rdPend_reg <= rdEn;
      rdSub_reg  <= crossNeg;
    end
  end

  // Pending corrections drain one pulse per idle cycle of the nominal stream.
  always_comb begin
    addVal = '0;
    if (rdPend_reg) begin
      addVal = rdSub_reg ? -PEND_W'(rdData) : PEND_W'(rdData);
    end
    emitCorr     = stepReady_reg && !stepValid && (pending_reg != '0);
    pending_next = pending_reg + addVal;
    if (emitCorr) begin
      pending_next = (pending_reg > 0) ? pending_next - PEND_W'(1)
                                       : pending_next + PEND_W'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pending_reg <= '0;
      total_reg   <= '0;
    end else begin
      pending_reg <= pending_next;
      if (emitCorr) begin
        total_reg <= (pending_reg > 0) ? total_reg + TOTAL_W'(1)
                                       : total_reg - TOTAL_W'(1);
      end
    end
  end

  // Two-entry buffer in front of the drive; a stall there stalls the source.
  always_comb begin
    push     = stepTake || emitCorr;
    pop      = valid_reg && driveReady;
    pushData = stepTake ? '{dir: stepDir, isCorr: 1'b0}
                        : '{dir: (pending_reg > 0), isCorr: 1'b1};
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + BUF_ONE;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - BUF_ONE;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg       <= BUF_EMPTY;
      valid_reg     <= 1'b0;
      stepReady_reg <= 1'b0;
      head_reg      <= '0;
      tail_reg      <= '0;
    end else begin
      cnt_reg       <= cnt_next;
      valid_reg     <= (cnt_next != BUF_EMPTY);
      stepReady_reg <= (cnt_next != BUF_FULL);
      if (push && !pop) begin
        if (cnt_reg == BUF_EMPTY) begin
          head_reg <= pushData;
        end else begin
          tail_reg <= pushData;
        end
      end else if (pop && !push) begin
        head_reg <= tail_reg;
      end else if (push && pop) begin
        if (cnt_reg == BUF_ONE) begin
          head_reg <= pushData;
        end else begin
          head_reg <= tail_reg;
          tail_reg <= pushData;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ackReg    <= 1'b0;
      refReg    <= 1'b0;
      activeReg <= 1'b0;
    end else begin
      ackReg    <= wrOk;
      refReg    <= tblWr.we && !wrOk;
      activeReg <= active;
    end
  end

  assign tblWrAck      = ackReg;
  assign tblWrRefused  = refReg;
  assign stepReady     = stepReady_reg;
  assign driveValid    = valid_reg;
  assign drivePulse    = head_reg;
  assign compActive    = activeReg;
  assign tableClearing = clearing_reg;
  assign compTotal     = total_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  corr_range_a: assert property (ackReg |-> $past(tblWr.data) >= CORR_MIN
    && $past(tblWr.data) <= CORR_MAX) else $error("stored correction out of range");
  wr_privilege_a: assert property (ackReg |-> $past(privLevel) == PRIV_EDIT
    && $past(paramWriteOn)) else $error("table write taken without privilege");
  zero_interval_a: assert property (cfg.interval == '0 |=> !rdPend_reg)
    else $error("correction read with zero interval");
  rehome_needed_a: assert property ((mode_reg == MODE_RUN && cfgChanged)
    |=> mode_reg == MODE_UNHOMED ##0 !rdEn) else $error("change did not suppress");
  home_entry_a: assert property ($rose(mode_reg == MODE_RUN) |-> $past(homeDone))
    else $error("run entered without zero return");
  origin_zero_a: assert property ((rdEn && cfg.origin == ORIGIN_POS_ONLY)
    |-> crossPos && sel[ADDR_W-1:0] == ADDR_W'(idx_reg + 1)) else $error("origin 0 map");
  origin_top_a: assert property ((rdEn && cfg.origin == ORIGIN_NEG_ONLY)
    |-> crossNeg && sel[ADDR_W-1:0] == ADDR_W'(idx_reg + 255)) else $error("origin 255 map");
  entry_range_a: assert property (rdEn |-> sel[ADDR_W-1:0] >= cfg.minPos
    && sel[ADDR_W-1:0] <= cfg.maxPos) else $error("entry outside min..max");
  merge_sign_a: assert property ((rdPend_reg && rdSub_reg && rdData > 0
    && !emitCorr) |=> pending_reg < $past(pending_reg)) else $error("reverse not subtracted");
  total_step_a: assert property (emitCorr ##1 valid_reg |-> ##0
    total_reg != $past(total_reg)) else $error("correction pulse not counted");
  pos_cross_c: cover property (rdEn && crossPos);
  neg_cross_c: cover property (rdEn && crossNeg);
  buffer_full_c: cover property (cnt_reg == BUF_FULL ##1 pop);
  corr_sent_c: cover property (emitCorr ##[1:4] pop);
endmodule : leadscrew_pitch_error_compensator

// file: sim/drive_model.sv
/*
  Servo drive stand-in that takes command pulses and keeps the net nominal and correction counts.
  Assumes the valid/ready pulse stream on ref_clk; slow mode takes one pulse in three cycles.
*/
`timescale 1ns/1ps
module drive_model (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       slow,
  input  wire logic       driveValid,
  input  pec_pkg::pulse_s drivePulse,
  output logic            driveReady,
  output int              nomNet,
  output int              corrNet
);
  import pec_pkg::*;
  logic [1:0] phaseReg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phaseReg <= 2'h0;
    end else begin
      phaseReg <= (phaseReg == 2'h2) ? 2'h0 : phaseReg + 2'h1;
    end
  end

  assign driveReady = !slow || (phaseReg == 2'h0);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      nomNet  <= 0;
      corrNet <= 0;
    end else if (driveValid && driveReady) begin
      if (drivePulse.isCorr) begin
        corrNet <= corrNet + (drivePulse.dir ? 1 : -1);
      end else begin
        nomNet <= nomNet + (drivePulse.dir ? 1 : -1);
      end
    end
  end
endmodule : drive_model

// file: sim/testbench.sv
/*
  Self-checking testbench for the pitch error compensator with a drive model on its output.
  Assumes the design clears its table after reset and takes steps by valid/ready.
*/
`timescale 1ns/1ps
module testbench;
  import pec_pkg::*;
  logic                        ref_clk = 1'b0;
  logic                        reset = 1'b1;
  comp_cfg_s                   cfg = '0;
  logic [1:0]                  privLevel = 2'h2;
  logic                        paramWriteOn = 1'b1;
  tbl_wr_s                     tblWr = '0;
  logic                        homeDone = 1'b0;
  logic                        stepValid = 1'b0;
  logic                        stepDir = 1'b0;
  logic                        slow = 1'b0;
  logic                        tblWrAck, tblWrRefused, stepReady, driveValid, driveReady;
  logic                        compActive, tableClearing;
  pulse_s                      drivePulse;
  logic signed [TOTAL_W-1:0]   compTotal;
  int                          nomNet, corrNet;
  int                          failures = 0;
  int                          samples_checked = 0;
  int                          cycles = 0;
  int                          expTot = 0;
  int                          expNom = 0;
  localparam comp_cfg_s CFG0 = '{1'b1, 10'h000, 10'h000, 10'h3ff, 20'h003e8};

  leadscrew_pitch_error_compensator u_leadscrew_pitch_error_compensator (
    .ref_clk(ref_clk), .reset(reset), .cfg(cfg), .privLevel(privLevel),
    .paramWriteOn(paramWriteOn), .tblWr(tblWr), .tblWrAck(tblWrAck),
    .tblWrRefused(tblWrRefused), .homeDone(homeDone), .stepValid(stepValid),
    .stepDir(stepDir), .stepReady(stepReady), .driveValid(driveValid),
    .drivePulse(drivePulse), .driveReady(driveReady), .compActive(compActive),
    .tableClearing(tableClearing), .compTotal(compTotal)
  );

  drive_model u_drive_model (
    .ref_clk(ref_clk), .reset(reset), .slow(slow), .driveValid(driveValid),
    .drivePulse(drivePulse), .driveReady(driveReady), .nomNet(nomNet), .corrNet(corrNet)
  );

  always #10 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic edit(input logic [9:0] a, input logic signed [12:0] d, input logic ok);
    @(posedge ref_clk);
    tblWr <= '{1'b1, a, d};
    @(posedge ref_clk);
    tblWr.we <= 1'b0;
    @(negedge ref_clk);
    check(tblWrAck, ok);
    check(tblWrRefused, !ok);
  endtask : edit

  task automatic home(input comp_cfg_s c, input logic act);
    @(posedge ref_clk);
    cfg <= c;
    @(posedge ref_clk);
    homeDone <= 1'b1;
    @(posedge ref_clk);
    homeDone <= 1'b0;
    repeat (3) @(negedge ref_clk);
    check(compActive, act);
  endtask : home

  // Each step is followed by one idle cycle so that corrections can be merged.
  task automatic move(input logic dir, input int n);
    int k;
    for (k = 0; k < n; k++) begin
      @(posedge ref_clk);
      stepValid <= 1'b1;
      stepDir   <= dir;
      @(negedge ref_clk);
      while (!stepReady) @(negedge ref_clk);
      @(posedge ref_clk);
      stepValid <= 1'b0;
    end
    expNom += dir ? n : -n;
    repeat (60) @(negedge ref_clk);
    check(compTotal, expTot);
    check(corrNet, expTot);
    check(nomNet, expNom);
  endtask : move

  task automatic test_edits();
    edit(10'h001, 13'sd7, 1'b0);
    @(posedge ref_clk);
    while (tableClearing === 1'b1) @(posedge ref_clk);
    privLevel <= 2'h1;
    edit(10'h001, 13'sd7, 1'b0);
    privLevel    <= 2'h2;
    paramWriteOn <= 1'b0;
    edit(10'h001, 13'sd7, 1'b0);
    paramWriteOn <= 1'b1;
    edit(10'h003, 13'sd2551, 1'b0);
    edit(10'h003, -13'sd2550, 1'b1);
    edit(10'h001, 13'sd7, 1'b1);
    edit(10'h002, -13'sd6, 1'b1);
    edit(10'h03c, 13'sd6, 1'b1);
    edit(10'h03d, 13'sd4, 1'b1);
    $display("test edits done");
  endtask : test_edits

  task automatic test_origin0();
    home(CFG0, 1'b1);
    expTot = 1;
    move(1'b1, 2000);
    edit(10'h005, 13'sd0, 1'b1);
    repeat (2) @(negedge ref_clk);
    check(compActive, 1'b0);
    move(1'b0, 1000);
    home(CFG0, 1'b1);
    move(1'b0, 1000);
    move(1'b1, 1000);
    $display("test origin0 done");
  endtask : test_origin0

  task automatic test_origin60();
    comp_cfg_s c;
    c = CFG0;
    c.origin = 10'h03c;
    slow <= 1'b1;
    home(c, 1'b1);
    expTot -= 6;
    move(1'b0, 1000);
    expTot += 10;
    move(1'b1, 2000);
    slow <= 1'b0;
    $display("test origin60 done");
  endtask : test_origin60

  task automatic test_off();
    comp_cfg_s c;
    c = CFG0;
    c.enable = 1'b0;
    home(c, 1'b0);
    c = CFG0;
    c.interval = 20'h00000;
    home(c, 1'b0);
    move(1'b1, 1000);
    c.interval = 20'h003e7;
    home(c, 1'b0);
    $display("test off done");
  endtask : test_off

  task automatic test_origin255();
    comp_cfg_s c;
    c = CFG0;
    c.origin = ORIGIN_NEG_ONLY;
    edit(10'h0ff, 13'sd2, 1'b1);
    edit(10'h0fe, -13'sd7, 1'b1);
    home(c, 1'b1);
    move(1'b1, 1000);
    move(1'b0, 1000);
    expTot += 5;
    move(1'b0, 2000);
    c.maxPos = 10'h0fe;
    home(c, 1'b1);
    move(1'b0, 1000);
    $display("test origin255 done");
  endtask : test_origin255

  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    test_edits();
    test_origin0();
    test_origin60();
    test_off();
    test_origin255();
    report_and_stop();
  end
endmodule : testbench
